// ==== logic/boot_guard_pkg.sv ====
package boot_guard_pkg;
  localparam logic [15:0] REGION_LO      = 16'h1000;
  localparam logic [15:0] REGION_HI      = 16'h17ff;
  localparam logic [15:0] GATEWAY_LO     = 16'h1000;
  localparam logic [15:0] GATEWAY_HI     = 16'h100f;
  localparam logic [15:0] KEY_LO_ADDR    = 16'h17fc;
  localparam logic [15:0] KEY_HI_ADDR    = 16'h17fe;
  localparam logic [15:0] START_VEC_ADDR = 16'h17fa;
  localparam logic [15:0] SIG1_ADDR      = 16'h17f6;
  localparam logic [15:0] SIG2_ADDR      = 16'h17f4;
  localparam logic [15:0] PROT_VEC_ADDR  = 16'h17f2;
  localparam logic [15:0] SIG1_VALUE     = 16'hc35a;
  localparam logic [15:0] SIG2_VALUE     = 16'h3ca5;
  localparam logic [15:0] KEY_ZERO       = 16'h0000;
  localparam logic [15:0] KEY_ONES       = 16'hffff;
  localparam int          DEC_DEBUG_BIT  = 0;
  localparam int          DEC_LOADER_BIT = 1;
  localparam logic [7:0]  OFF_PROT_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_DECISION   = 8'h08;
  localparam logic [7:0]  OFF_RX_LEN     = 8'h0c;
  localparam int          ST_SIG_OK      = 0;
  localparam int          ST_DEBUG_OPEN  = 1;
  localparam int          ST_LOADER_RUN  = 2;
  localparam int          ST_INVOKE      = 3;
  localparam int          ST_RX_DONE     = 4;
  localparam int          CTRL_PROT_EN   = 0;
  localparam logic [7:0]  RX_LEN_RESET   = 8'h04;
  typedef enum logic [2:0] {
    S_KEY0 = 3'b000, S_KEY1 = 3'b001, S_SIG1 = 3'b011, S_SIG2 = 3'b010,
    S_PVEC = 3'b110, S_CALL = 3'b111, S_SVEC = 3'b101, S_RUN  = 3'b100
  } seq_state_type;
endpackage

// ==== logic/boot_region_guard_startup.sv ====
`timescale 1ns/1ps
// Contract
// - Region 0x1000..0x17FF is the guarded loader area
// - Protected: outside code cannot read/jump in
// - Gateway 0x1000..0x100F open to outside code
// - Gateway code may jump anywhere in region
// - Key all 00 or all FF leaves debug open
// - Loader starts at word from 0x17FA
// - Signature 1 at 0x17F6 must be C35A
// - Signature 2 at 0x17F4 must be 3CA5
// - Protect routine entry read from 0x17F2
// - Signatures checked before protect routine call
// - Protect routine runs before application code only when both signatures match
// - Protect routine programs protection on every startup with valid signatures
// - Decision bit 0 forces debug open
// - Decision bit 1 starts loader, else not
// - Invoke flag records pin toggle sequence
// - Loader uses RAM vectors, not flash vectors
// - Receive completes only after all command bytes
module boot_region_guard_startup
  import boot_guard_pkg::*;
#(
  parameter logic [15:0] APP_RESET_PC  = 16'h8000,
  parameter int          INVOKE_EDGES  = 2
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  output logic             o_flash_rd,
  output logic [15:0]      o_flash_addr,
  input  wire logic        i_flash_ack,
  input  wire logic [15:0] i_flash_data,
  output logic             o_call_req,
  output logic [15:0]      o_call_pc,
  input  wire logic        i_protect_done,
  input  wire logic [1:0]  i_decision,
  output logic             o_core_hold,
  output logic             o_run,
  output logic             o_run_loader,
  output logic [15:0]      o_run_pc,
  output logic             o_debug_open,
  input  wire logic        i_acc_valid,
  input  wire logic [15:0] i_acc_addr,
  input  wire logic [15:0] i_acc_src_pc,
  output logic             o_acc_block,
  output logic             o_vec_ram_sel,
  input  wire logic        i_invoke_pin,
  input  wire logic        i_rx_byte
);
  seq_state_type state_r, state_nxt;
  logic [15:0] key_lo_r, key_hi_r, pvec_r, run_pc_r;
  logic        key_valid_r, sig_ok_r, ctrl_written_r, prot_en_r, run_loader_r;
  logic        debug_open_r, invoke_r, rx_done_r;
  logic [1:0]  decision_r;
  logic [7:0]  rx_len_r, rx_cnt_r;
  logic [1:0]  pin_sync_r;
  logic        pin_prev_r;
  logic [7:0]  edge_cnt_r;
  logic [31:0] prdata_r;

  // Flash read sequencing
  wire ack         = i_flash_ack && o_flash_rd;
  wire sig1_match  = (i_flash_data == SIG1_VALUE);
  wire sig2_match  = (i_flash_data == SIG2_VALUE);
  wire call_taken  = (state_r == S_CALL) && i_protect_done && ctrl_written_r;
  wire want_loader = i_decision[DEC_LOADER_BIT];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_KEY0: if (ack) state_nxt = S_KEY1;
      S_KEY1: if (ack) state_nxt = S_SIG1;
      S_SIG1: if (ack) state_nxt = sig1_match ? S_SIG2 : S_RUN;
      S_SIG2: if (ack) state_nxt = sig2_match ? S_PVEC : S_RUN;
      S_PVEC: if (ack) state_nxt = S_CALL;
      S_CALL: if (call_taken) state_nxt = want_loader ? S_SVEC : S_RUN;
      S_SVEC: if (ack) state_nxt = S_RUN;
      S_RUN:  state_nxt = S_RUN;
    endcase
  end

  always_comb begin
    o_flash_addr = KEY_LO_ADDR;
    unique case (state_r)
      S_KEY0:  o_flash_addr = KEY_LO_ADDR;
      S_KEY1:  o_flash_addr = KEY_HI_ADDR;
      S_SIG1:  o_flash_addr = SIG1_ADDR;
      S_SIG2:  o_flash_addr = SIG2_ADDR;
      S_PVEC:  o_flash_addr = PROT_VEC_ADDR;
      S_SVEC:  o_flash_addr = START_VEC_ADDR;
      S_CALL:  o_flash_addr = PROT_VEC_ADDR;
      S_RUN:   o_flash_addr = KEY_LO_ADDR;
    endcase
  end

  assign o_flash_rd = (state_r != S_CALL) && (state_r != S_RUN);
  assign o_call_req = (state_r == S_CALL);
  assign o_call_pc  = pvec_r;
  assign o_core_hold = (state_r != S_RUN);
  assign o_run       = (state_r == S_RUN);
  assign o_run_loader = run_loader_r;
  assign o_run_pc    = run_pc_r;
  assign o_debug_open = debug_open_r;
  assign o_vec_ram_sel = run_loader_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= S_KEY0;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_lo_r    <= KEY_ZERO;
      key_hi_r    <= KEY_ZERO;
      key_valid_r <= 1'b0;
      pvec_r      <= 16'h0000;
      sig_ok_r    <= 1'b0;
    end else if (ack) begin
      if (state_r == S_KEY0) key_lo_r <= i_flash_data;
      if (state_r == S_KEY1) begin
        key_hi_r    <= i_flash_data;
        key_valid_r <= 1'b1;
      end
      if (state_r == S_PVEC) pvec_r <= i_flash_data;
      if (state_r == S_SIG2) sig_ok_r <= sig2_match;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      decision_r   <= 2'b00;
      run_loader_r <= 1'b0;
      run_pc_r     <= APP_RESET_PC;
    end else if (call_taken) begin
      decision_r <= i_decision;
    end else if (ack && state_r == S_SVEC) begin
      run_loader_r <= 1'b1;
      run_pc_r     <= i_flash_data;
    end
  end

  // Debug lock decode
  wire key_blank = ((key_lo_r == KEY_ZERO) && (key_hi_r == KEY_ZERO)) ||
                   ((key_lo_r == KEY_ONES) && (key_hi_r == KEY_ONES));
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      debug_open_r <= 1'b0;
    end else begin
      debug_open_r <= key_valid_r && (key_blank || decision_r[DEC_DEBUG_BIT]);
    end
  end

  // Access guard
  wire addr_in_region = (i_acc_addr >= REGION_LO) && (i_acc_addr <= REGION_HI);
  wire src_in_region  = (i_acc_src_pc >= REGION_LO) && (i_acc_src_pc <= REGION_HI);
  wire addr_in_gate   = (i_acc_addr >= GATEWAY_LO) && (i_acc_addr <= GATEWAY_HI);
  // Gateway code lies inside the region, so its jumps pass
  assign o_acc_block = i_acc_valid && prot_en_r && addr_in_region &&
                       !src_in_region && !addr_in_gate;

  // Invoke pin toggle detection
  wire pin_rise = pin_sync_r[1] && !pin_prev_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_sync_r <= 2'b00;
      pin_prev_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], i_invoke_pin};
      pin_prev_r <= pin_sync_r[1];
    end
  end

  // APB slave
  wire        apb_acc   = i_psel && i_penable;
  wire        apb_wr    = apb_acc && i_pwrite;
  wire        sel_ctrl  = (i_paddr == OFF_PROT_CTRL);
  wire        sel_stat  = (i_paddr == OFF_STATUS);
  wire        sel_dec   = (i_paddr == OFF_DECISION);
  wire        sel_rxl   = (i_paddr == OFF_RX_LEN);
  wire        mapped    = sel_ctrl || sel_stat || sel_dec || sel_rxl;
  wire        clr_inv   = apb_wr && sel_stat && i_pwdata[ST_INVOKE];
  wire        clr_rx    = apb_wr && sel_stat && i_pwdata[ST_RX_DONE];
  wire        inv_set   = pin_rise && (edge_cnt_r == 8'(INVOKE_EDGES - 1));
  wire        rx_set    = i_rx_byte && (rx_cnt_r == rx_len_r - 8'h01);
  wire [31:0] status_w  = {27'h0, rx_done_r, invoke_r, run_loader_r, debug_open_r, sig_ok_r};
  wire [31:0] rd_mux    = sel_ctrl ? {31'h0, prot_en_r} :
                          sel_stat ? status_w :
                          sel_dec  ? {30'h0, decision_r} :
                          sel_rxl  ? {24'h0, rx_len_r} : 32'h0;

  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !mapped;
  assign o_prdata  = prdata_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_r <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prot_en_r      <= 1'b0;
      ctrl_written_r <= 1'b0;
      rx_len_r       <= RX_LEN_RESET;
    end else if (apb_wr) begin
      if (sel_ctrl) begin
        prot_en_r      <= i_pwdata[CTRL_PROT_EN];
        ctrl_written_r <= 1'b1;
      end
      if (sel_rxl) rx_len_r <= i_pwdata[7:0];
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      invoke_r   <= 1'b0;
      edge_cnt_r <= 8'h00;
      rx_done_r  <= 1'b0;
      rx_cnt_r   <= 8'h00;
    end else begin
      if (pin_rise) edge_cnt_r <= inv_set ? 8'h00 : edge_cnt_r + 8'h01;
      invoke_r <= inv_set | (invoke_r & ~clr_inv);
      if (i_rx_byte) rx_cnt_r <= rx_set ? 8'h00 : rx_cnt_r + 8'h01;
      rx_done_r <= rx_set | (rx_done_r & ~clr_rx);
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  bad_sig1_skip_a: assert property ((state_r == S_SIG1) && ack && !sig1_match |=>
    (state_r == S_RUN) && !o_run_loader && (o_run_pc == APP_RESET_PC))
    else $error("bad signature 1 did not skip to application");
  bad_sig2_skip_a: assert property ((state_r == S_SIG2) && ack && !sig2_match |=>
    o_run && !o_call_req) else $error("bad signature 2 did not skip");
  call_after_sig_a: assert property ($rose(o_call_req) |-> sig_ok_r &&
    $past(state_r) == S_PVEC) else $error("protect call without signature check");
  call_pc_vec_a: assert property ((state_r == S_PVEC) && ack |=>
    o_call_req && (o_call_pc == $past(i_flash_data))) else $error("wrong protect entry");
  hold_until_run_a: assert property ($fell(o_core_hold) |->
    (($past(state_r) == S_CALL) || ($past(state_r) == S_SVEC) ||
     ($past(state_r) == S_SIG1) || ($past(state_r) == S_SIG2)))
    else $error("core released before startup checks ended");
  loader_pc_a: assert property ((state_r == S_SVEC) && ack |=>
    o_run && o_run_loader && (o_run_pc == $past(i_flash_data)))
    else $error("loader start vector not used");
  no_loader_a: assert property (call_taken && !i_decision[1] |=>
    o_run && !o_run_loader) else $error("loader started without request");
  ctrl_first_a: assert property ((state_r == S_CALL) && !ctrl_written_r |=>
    state_r == S_CALL) else $error("protect return before control write");
  guard_block_a: assert property (i_acc_valid && prot_en_r &&
    (i_acc_addr > GATEWAY_HI) && (i_acc_addr <= REGION_HI) &&
    (i_acc_src_pc < REGION_LO) |-> o_acc_block) else $error("outside access not blocked");
  gate_open_a: assert property (i_acc_valid && (i_acc_addr >= GATEWAY_LO) &&
    (i_acc_addr <= GATEWAY_HI) |-> !o_acc_block) else $error("gateway access blocked");
  debug_key_a: assert property (key_valid_r && $stable(key_lo_r) &&
    key_blank |=> o_debug_open) else $error("blank key left debug locked");
  debug_lock_a: assert property (key_valid_r && !key_blank &&
    !decision_r[0] |=> !o_debug_open) else $error("debug open without key or override");
  invoke_sticky_a: assert property (inv_set |=> invoke_r)
    else $error("invoke flag lost");
  rx_done_a: assert property (rx_done_r && !$past(rx_done_r) |->
    $past(i_rx_byte) && ($past(rx_cnt_r) == $past(rx_len_r) - 8'h01))
    else $error("receive done before all bytes");

  loader_path_c: cover property ((state_r == S_SVEC) ##1 o_run && o_run_loader);
  app_path_c:    cover property (call_taken && !i_decision[1]);
  bad_sig_c:     cover property ((state_r == S_SIG1) && ack && !sig1_match);
  block_c:       cover property (o_acc_block);
endmodule

// ==== tb/flash_model.sv ====
`timescale 1ns/1ps
module flash_model
  import boot_guard_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  input  wire logic [3:0]  i_wait,
  input  wire logic [31:0] i_key,
  input  wire logic [15:0] i_sig1,
  input  wire logic [15:0] i_sig2,
  input  wire logic [15:0] i_pvec,
  input  wire logic [15:0] i_svec,
  output logic             o_ack,
  output logic [15:0]      o_data
);
  logic [3:0]  wait_r;
  logic [15:0] word;
  logic        take;
  assign take = i_rd && !o_ack && (wait_r >= i_wait);
  assign word = (i_addr == KEY_LO_ADDR)    ? i_key[15:0]  :
                (i_addr == KEY_HI_ADDR)    ? i_key[31:16] :
                (i_addr == SIG1_ADDR)      ? i_sig1       :
                (i_addr == SIG2_ADDR)      ? i_sig2       :
                (i_addr == PROT_VEC_ADDR)  ? i_pvec       :
                (i_addr == START_VEC_ADDR) ? i_svec : ~o_data;
  // Data bus shows garbage outside an acknowledged cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_r <= 4'h0;
      o_ack  <= 1'b0;
      o_data <= 16'h0000;
    end else begin
      o_ack  <= take;
      wait_r <= (take || !i_rd) ? 4'h0 : wait_r + 4'h1;
      o_data <= take ? word : ~o_data;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import boot_guard_pkg::*;
  localparam logic [15:0] APP_PC = 16'h8000;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, flash_ack, run_loader;
  logic pready, pslverr, flash_rd, call_req, protect_done = 0, core_hold, run;
  logic debug_open, acc_valid = 0, acc_block, vec_ram_sel, invoke_pin = 0, rx_byte = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, key = 32'h0, q;
  logic [15:0] flash_addr, flash_data, call_pc, run_pc, acc_addr = 0, acc_src_pc = 0;
  logic [15:0] sig1 = 0, sig2 = 0, pvec = 16'h1400, svec = 16'h1200;
  logic [1:0]  decision = 2'b00;
  logic [3:0]  wt = 4'h3;
  logic        e;
  logic [47:0] gtab [9];
  int          err_count = 0, n_checks = 0;
  always #50 clk = ~clk;
  boot_region_guard_startup #(.APP_RESET_PC(APP_PC), .INVOKE_EDGES(2)) uut (
    .i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .o_flash_rd(flash_rd),
    .o_flash_addr(flash_addr), .i_flash_ack(flash_ack), .i_flash_data(flash_data),
    .o_call_req(call_req), .o_call_pc(call_pc), .i_protect_done(protect_done),
    .i_decision(decision), .o_core_hold(core_hold), .o_run(run),
    .o_run_loader(run_loader), .o_run_pc(run_pc), .o_debug_open(debug_open),
    .i_acc_valid(acc_valid), .i_acc_addr(acc_addr), .i_acc_src_pc(acc_src_pc),
    .o_acc_block(acc_block), .o_vec_ram_sel(vec_ram_sel), .i_invoke_pin(invoke_pin),
    .i_rx_byte(rx_byte));
  flash_model flash (.i_clk(clk), .i_reset_n(rst_n), .i_rd(flash_rd), .i_addr(flash_addr),
    .i_wait(wt), .i_key(key), .i_sig1(sig1), .i_sig2(sig2), .i_pvec(pvec), .i_svec(svec),
    .o_ack(flash_ack), .o_data(flash_data));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task done(input logic [1:0] dec);
    @(posedge clk);
    protect_done <= 1'b1;
    decision <= dec;
    @(posedge clk);
    protect_done <= 1'b0;
  endtask
  task boot(input logic [31:0] k, input logic [15:0] s1, input logic [15:0] s2,
            input logic [1:0] dec, input logic early);
    logic ok;
    ok = (s1 === SIG1_VALUE) && (s2 === SIG2_VALUE);
    @(posedge clk);
    key <= k;
    sig1 <= s1;
    sig2 <= s2;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 300 && !(call_req || run); i++) @(negedge clk);
    chk("call_req", ok, call_req);
    chk("core_hold", ok, core_hold);
    if (ok) begin
      chk("call_pc", pvec, call_pc);
      if (early) begin
        done(dec);
        @(negedge clk);
        chk("call_held", 1'b1, call_req);
      end
      apb(1'b1, OFF_PROT_CTRL, 32'h1);
      done(dec);
    end
    for (int i = 0; i < 300 && !run; i++) @(negedge clk);
    chk("run", 1'b1, run);
    // Debug decode follows the stored decision one cycle later
    @(negedge clk);
    chk("run_loader", ok & dec[1], run_loader);
    chk("run_pc", (ok & dec[1]) ? svec : APP_PC, run_pc);
    chk("debug_open", (k == 0) || (&k) || (ok & dec[0]), debug_open);
    chk("vec_ram_sel", ok & dec[1], vec_ram_sel);
    chk("core_hold_end", 1'b0, core_hold);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict;
  end
  initial begin
    gtab = '{48'h1200_8000_0001, 48'h1005_8000_0000, 48'h100f_8000_0000,
             48'h1010_8000_0001, 48'h17ff_8000_0001, 48'h1800_8000_0000,
             48'h0fff_8000_0000, 48'h1400_1008_0000, 48'h1200_8000_0001};
    boot(32'h0, SIG1_VALUE, SIG2_VALUE, 2'b10, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h7, q & 32'h7);
    apb(1'b0, OFF_DECISION, 32'h0);
    chk("decision", 32'h2, q);
    wt <= 4'h0;
    boot(32'hffff_ffff, SIG1_VALUE, SIG2_VALUE, 2'b00, 1'b0);
    boot(32'h1234_5678, SIG1_VALUE, SIG2_VALUE, 2'b01, 1'b0);
    boot(32'h0000_ffff, SIG1_VALUE, SIG2_VALUE, 2'b00, 1'b0);
    boot(32'h0, 16'hc35b, SIG2_VALUE, 2'b10, 1'b0);
    boot(32'hffff_ffff, SIG1_VALUE, 16'h3ca4, 2'b11, 1'b0);
    boot(32'h1234_5678, SIG1_VALUE, SIG2_VALUE, 2'b00, 1'b0);
    foreach (gtab[j]) begin
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_addr <= gtab[j][47:32];
      acc_src_pc <= gtab[j][31:16];
      @(negedge clk);
      chk("acc_block", gtab[j][0], acc_block);
    end
    apb(1'b1, OFF_PROT_CTRL, 32'h0);
    @(negedge clk);
    chk("acc_unprotected", 1'b0, acc_block);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 1'b1, e);
    chk("unmapped_data", 32'h0, q);
    apb(1'b0, OFF_RX_LEN, 32'h0);
    chk("rx_len", 32'h4, q);
    repeat (6) begin
      @(posedge clk);
      rx_byte <= ~rx_byte;
      invoke_pin <= ~invoke_pin;
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("rx_partial", 32'h8, q & 32'h18);
    repeat (2) begin
      @(posedge clk);
      rx_byte <= ~rx_byte;
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("rx_done", 32'h18, q & 32'h18);
    apb(1'b1, OFF_STATUS, 32'h18);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status_clear", 32'h0, q & 32'h18);
    apb(1'b1, OFF_RX_LEN, 32'h2);
    apb(1'b0, OFF_RX_LEN, 32'h0);
    chk("rx_len_wr", 32'h2, q);
    repeat (4) begin
      @(posedge clk);
      rx_byte <= ~rx_byte;
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("rx_short", 32'h10, q & 32'h10);
    give_verdict;
  end
endmodule
